/* File: hdl/rtg_regs.vh */
// Constants for the raster timing generator
`ifndef RTG_REGS_VH
`define RTG_REGS_VH

// Strobe ring
`define RTG_RING_LEN 7
`define RTG_RING_LOAD 7'h01

// Line counter, modulus and decodes
`define RTG_LINE_W 6
`define RTG_LINE_LAST 6'h2c
`define RTG_LINE_ON 6'h01
`define RTG_LINE_FIVE 6'h05
`define RTG_LINE_OFF 6'h0b
`define RTG_LINE_TWSEVEN 6'h1b
`define RTG_LINE_FORTYTWO 6'h2a
`define RTG_LINE_HALF 6'h2c

// Field counter, 60 Hz variant
`define RTG_FIELD_W 10
`define RTG_F60_LAST 10'h20c
`define RTG_F60_DEC_A 10'h073
`define RTG_F60_DEC_B 10'h074

// Field counter, 50 Hz variant
`define RTG_F50_LAST 10'h274
`define RTG_F50_DEC_A 10'h0ab
`define RTG_F50_DEC_B 10'h0ac

// Field counter bit positions
`define RTG_FIELD_BIT0 0
`define RTG_FIELD_BIT4 4

`endif

/* File: hdl/rtg_pin_sync.v */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none

module rtg_pin_sync #(
   parameter WIDTH = 3,
   parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
   input wire clk,
   input wire nrst,
   input wire [WIDTH-1:0] pin_in,
   output wire [WIDTH-1:0] pin_out
);

   reg [WIDTH-1:0] stage1;
   reg [WIDTH-1:0] stage2;
   reg [WIDTH-1:0] stage3;
   reg [WIDTH-1:0] level;

   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         // Level changes only once stages two and three agree
         always @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               stage1[i] <= INIT[i];
               stage2[i] <= INIT[i];
               stage3[i] <= INIT[i];
               level[i] <= INIT[i];
            end else begin
               stage1[i] <= pin_in[i];
               stage2[i] <= stage1[i];
               stage3[i] <= stage2[i];
               if (stage2[i] == stage3[i]) begin
                  level[i] <= stage3[i];
               end
            end
         end
      end
   endgenerate

   assign pin_out = level;

endmodule // rtg_pin_sync

`default_nettype wire

/* File: hdl/rtg_timing.v */
// Raster timing generator: half-rate clock, strobe ring, line and field counters
//
// Summary of operation
// - Master clock halved by a toggle stage; half rate times reset and ring.
// - Half-rate clock also leaves as pixel shift clock.
// - Seven-bit ring gives seven phases, one half period each, period seven.
// - Ring reset high loads phase zero high, phases one to six low.
// - Power-on input low asserts system reset both polarities and holds ring reset.
// - Power-on high releases system reset; ring reset drops next half-rate rise.
// - After reset the ring shifts right on half-rate falls, phase six recirculates.
// - Button low asserts system reset until the button is released.
// - Manual ring reset lasts one half-rate period, rise to rise.
// - Manual ring reset held off while line drive input is low.
// - Line counter steps at the trailing edge of each inverted phase-three strobe, except one ended by a ring reset load.
// - Line counts 1, 5, 11, 27, 42, 44 decode into six pulses.
// - Line counter wraps from 44 to zero, modulus 45.
// - Field counter steps at the trailing edge of each half-line tick, except the tick whose start cleared it.
// - At 524 vertical drive sets; next half-line tick clears the count.
// - Field bits zero and four ANDed give the vertical drive end pulse.
// - 60 Hz decodes 115, 116, 524 as active-low one-tick pulses.
// - Field counter bit four leaves as an audible tone.
// - Field flip-flop toggles at the leading edge of every end decode.
// - Field A and field B gates leave as complementary outputs.
// - 50 Hz variant divides by 629, decoding 171, 172, 628.
// - 50 Hz field counter runs to 628 then clears on the next tick.
`include "rtg_regs.vh"
`timescale 1ns/10ps
`default_nettype none

module rtg_timing #(
   parameter FIFTY_HZ = 0
) (
   input wire clk,
   input wire nrst,
   input wire power_on_ok,
   input wire reset_button_n,
   input wire monitor_line_drive_n,
   output wire pixel_shift_clk,
   output wire system_reset,
   output wire system_reset_n,
   output wire ring_reset,
   output wire [6:0] phase_strobe,
   output wire [6:0] phase_strobe_n,
   output wire phase_zero_strobe,
   output wire phase_three_strobe,
   output wire phase_six_strobe,
   output wire line_drive_on_pulse,
   output wire line_count_five_pulse,
   output wire line_drive_off_pulse,
   output wire line_count_twentyseven_pulse,
   output wire line_count_fortytwo_pulse,
   output wire half_line_tick,
   output wire field_decode_a_n,
   output wire field_decode_b_n,
   output wire field_end_decode_n,
   output wire vdrive_end_pulse,
   output wire tone_out,
   output wire field_a_gate,
   output wire field_b_gate,
   output wire [5:0] line_count,
   output wire [9:0] field_count
);

   // Variant selection of field decodes
   localparam [9:0] FIELD_LAST = FIFTY_HZ ? `RTG_F50_LAST : `RTG_F60_LAST;
   localparam [9:0] FIELD_DEC_A = FIFTY_HZ ? `RTG_F50_DEC_A : `RTG_F60_DEC_A;
   localparam [9:0] FIELD_DEC_B = FIFTY_HZ ? `RTG_F50_DEC_B : `RTG_F60_DEC_B;

   // Reset circuit states, one-hot
   localparam [2:0] ST_POWER = 3'h1;
   localparam [2:0] ST_RUN = 3'h2;
   localparam [2:0] ST_PULSE = 3'h4;

   wire [2:0] pins_sync;
   wire por_s;
   wire button_n_s;
   wire line_drive_n_s;

   reg half_clk;
   wire half_rise;
   wire half_fall;

   reg [2:0] rst_state;
   reg [2:0] next_rst_state;
   reg ring_rst;
   reg next_ring_rst;
   reg press_pending;
   reg next_press_pending;
   reg button_prev;
   wire button_press;
   reg sys_rst;

   reg [6:0] ring;
   wire line_step;

   reg [5:0] line_cnt;
   reg [5:0] next_line_cnt;
   reg [5:0] line_dec;
   wire field_step;
   wire field_lead;

   reg [9:0] field_cnt;
   reg [9:0] next_field_cnt;
   reg field_hold;
   reg next_field_hold;
   reg dec_a_n;
   reg dec_b_n;
   reg dec_end_n;
   reg vd_end;
   reg tone;
   reg field_ab;

   // Pins from outside the clock domain
   rtg_pin_sync #(
      .WIDTH(3),
      .INIT(3'h6)
   ) u_sync (
      .clk(clk),
      .nrst(nrst),
      .pin_in({monitor_line_drive_n, reset_button_n, power_on_ok}),
      .pin_out(pins_sync)
   );

   assign por_s = pins_sync[0];
   assign button_n_s = pins_sync[1];
   assign line_drive_n_s = pins_sync[2];

   // Half-rate toggle stage
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         half_clk <= 1'b0;
      end else begin
         half_clk <= ~half_clk;
      end
   end

   // Edge enables of the half-rate clock
   assign half_rise = ~half_clk;
   assign half_fall = half_clk;
   assign pixel_shift_clk = half_clk;

   // Button press edge detection
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         button_prev <= 1'b1;
      end else begin
         button_prev <= button_n_s;
      end
   end

   // Press is the falling edge of the synced button
   assign button_press = button_prev & ~button_n_s;

   // System reset, held by power-on or button
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sys_rst <= 1'b1;
      end else begin
         sys_rst <= ~por_s | ~button_n_s;
      end
   end

   assign system_reset = sys_rst;
   assign system_reset_n = ~sys_rst;

   // Reset circuit next-state logic
   always @* begin
      next_rst_state = rst_state;
      next_ring_rst = ring_rst;
      next_press_pending = press_pending;
      if (half_rise) begin
         case (rst_state)
            ST_POWER: begin
               next_ring_rst = 1'b1;
               if (por_s) begin
                  next_ring_rst = 1'b0;
                  next_rst_state = ST_RUN;
               end
            end
            ST_RUN: begin
               if (press_pending && line_drive_n_s) begin
                  next_ring_rst = 1'b1;
                  next_press_pending = 1'b0;
                  next_rst_state = ST_PULSE;
               end
            end
            ST_PULSE: begin
               next_ring_rst = 1'b0;
               next_rst_state = ST_RUN;
            end
            default: begin
               next_ring_rst = 1'b1;
               next_rst_state = ST_POWER;
            end
         endcase
      end
      if (!por_s) begin
         next_ring_rst = 1'b1;
         next_press_pending = 1'b0;
         next_rst_state = ST_POWER;
      end else if (button_press) begin
         next_press_pending = 1'b1;
      end
   end

   // Reset circuit registers
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_state <= ST_POWER;
         ring_rst <= 1'b1;
         press_pending <= 1'b0;
      end else begin
         rst_state <= next_rst_state;
         ring_rst <= next_ring_rst;
         press_pending <= next_press_pending;
      end
   end

   assign ring_reset = ring_rst;

   // Strobe ring: parallel load or shift right with recirculation
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ring <= `RTG_RING_LOAD;
      end else if (half_fall) begin
         if (ring_rst) begin
            ring <= `RTG_RING_LOAD;
         end else begin
            ring <= {ring[5:0], ring[6]};
         end
      end
   end

   assign phase_strobe = ring;
   assign phase_strobe_n = ~ring;
   assign phase_zero_strobe = ring[0];
   assign phase_three_strobe = ring[3];
   assign phase_six_strobe = ring[6];

   // Inverted phase three ends as the ring leaves phase three
   assign line_step = half_fall & ~ring_rst & ring[3];

   // Line counter next value, modulus 45
   always @* begin
      next_line_cnt = line_cnt;
      if (line_step) begin
         if (line_cnt == `RTG_LINE_LAST) begin
            next_line_cnt = 6'h00;
         end else begin
            next_line_cnt = line_cnt + 6'h01;
         end
      end
   end

   // Line counter and registered decodes
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         line_cnt <= 6'h00;
         line_dec <= 6'h00;
      end else begin
         line_cnt <= next_line_cnt;
         line_dec[0] <= (next_line_cnt == `RTG_LINE_ON);
         line_dec[1] <= (next_line_cnt == `RTG_LINE_FIVE);
         line_dec[2] <= (next_line_cnt == `RTG_LINE_OFF);
         line_dec[3] <= (next_line_cnt == `RTG_LINE_TWSEVEN);
         line_dec[4] <= (next_line_cnt == `RTG_LINE_FORTYTWO);
         line_dec[5] <= (next_line_cnt == `RTG_LINE_HALF);
      end
   end

   // Line decode pulses, each one count wide
   assign line_drive_on_pulse = line_dec[0];
   assign line_count_five_pulse = line_dec[1];
   assign line_drive_off_pulse = line_dec[2];
   assign line_count_twentyseven_pulse = line_dec[3];
   assign line_count_fortytwo_pulse = line_dec[4];
   assign half_line_tick = line_dec[5];
   assign line_count = line_cnt;

   // Half-line tick ends as the line counter leaves 44
   assign field_step = line_step & (line_cnt == `RTG_LINE_HALF);

   // Half-line tick begins as the line counter enters 44
   assign field_lead = line_step & (next_line_cnt == `RTG_LINE_HALF);

   // Field counter next value, 525 or 629; last count clears at the next tick's start
   // Trailing edge of that tick is swallowed, so zero spans one extra tick
   always @* begin
      next_field_cnt = field_cnt;
      next_field_hold = field_hold;
      if (field_lead && field_cnt == FIELD_LAST) begin
         next_field_cnt = 10'h000;
         next_field_hold = 1'b1;
      end else if (field_step) begin
         next_field_hold = 1'b0;
         if (!field_hold) begin
            next_field_cnt = field_cnt + 10'h001;
         end
      end
   end

   // Field counter and registered decodes
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         field_cnt <= 10'h000;
         field_hold <= 1'b0;
         dec_a_n <= 1'b1;
         dec_b_n <= 1'b1;
         dec_end_n <= 1'b1;
         vd_end <= 1'b0;
         tone <= 1'b0;
      end else begin
         field_cnt <= next_field_cnt;
         field_hold <= next_field_hold;
         dec_a_n <= ~(next_field_cnt == FIELD_DEC_A);
         dec_b_n <= ~(next_field_cnt == FIELD_DEC_B);
         dec_end_n <= ~(next_field_cnt == FIELD_LAST);
         vd_end <= next_field_cnt[`RTG_FIELD_BIT0] & next_field_cnt[`RTG_FIELD_BIT4];
         tone <= next_field_cnt[`RTG_FIELD_BIT4];
      end
   end

   // Field flip-flop toggles as the end decode begins
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         field_ab <= 1'b0;
      end else if (field_step && next_field_cnt == FIELD_LAST) begin
         field_ab <= ~field_ab;
      end
   end

   // Field outputs straight from flip-flops, field B gate through an inverter
   assign field_decode_a_n = dec_a_n;
   assign field_decode_b_n = dec_b_n;
   assign field_end_decode_n = dec_end_n;
   assign vdrive_end_pulse = vd_end;
   assign tone_out = tone;
   assign field_a_gate = field_ab;
   assign field_b_gate = ~field_ab;
   assign field_count = field_cnt;

endmodule // rtg_timing

`default_nettype wire

/* File: sim/rtg_sva.sv */
// Assertion checker for the raster timing generator
`include "rtg_regs.vh"
`timescale 1ns/10ps
`default_nettype none
module rtg_sva #(
   parameter FIFTY_HZ = 0
) (
   input wire clk,
   input wire nrst,
   input wire power_on_ok,
   input wire reset_button_n,
   input wire monitor_line_drive_n,
   input wire pixel_shift_clk,
   input wire system_reset,
   input wire system_reset_n,
   input wire ring_reset,
   input wire [6:0] phase_strobe,
   input wire half_line_tick,
   input wire field_end_decode_n,
   input wire vdrive_end_pulse,
   input wire tone_out,
   input wire field_a_gate,
   input wire field_b_gate,
   input wire [5:0] line_count,
   input wire [9:0] field_count
);
   localparam [9:0] LAST = FIFTY_HZ ? `RTG_F50_LAST : `RTG_F60_LAST;
   logic half_q, rst_q, ga_q, hold_q;
   logic [6:0] ring_q;
   logic [5:0] line_q;
   logic [9:0] field_q;
   // Ring shift edge and line counter step
   wire fall = half_q && !pixel_shift_clk;
   wire step = fall && phase_strobe[4];
   // Leading and trailing edges of the half-line tick
   wire lead = step && line_count == `RTG_LINE_HALF;
   wire trail = step && line_q == `RTG_LINE_HALF;
   // One-cycle copies of the design state
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         half_q <= 1'b1; // First toggle after reset is a rise
         hold_q <= 1'b0;
         rst_q <= 1'b1;
         ga_q <= 1'b0;
         ring_q <= 7'h01;
         line_q <= 6'h00;
         field_q <= 10'h000;
      end else begin
         half_q <= pixel_shift_clk;
         rst_q <= ring_reset;
         ga_q <= field_a_gate;
         ring_q <= phase_strobe;
         line_q <= line_count;
         field_q <= field_count;
         if (lead && field_q == LAST) begin
            hold_q <= 1'b1;
         end else if (trail) begin
            hold_q <= 1'b0;
         end
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   sequence s_rise_edge;
      $rose(pixel_shift_clk);
   endsequence
   sequence s_two_wide;
      ring_reset [*2] ##1 !ring_reset;
   endsequence
   property p_clocks;
      pixel_shift_clk != half_q && system_reset_n == !system_reset;
   endproperty
   a_clocks: assert property (p_clocks) else $error("half clock or reset pair wrong");
   property p_ring;
      $onehot(phase_strobe) && phase_strobe == (!fall ? ring_q : rst_q ? 7'h01 : {ring_q[5:0], ring_q[6]});
   endproperty
   a_ring: assert property (p_ring) else $error("strobe ring step wrong");
   property p_por;
      (!power_on_ok) [*8] |-> system_reset && ring_reset;
   endproperty
   a_por: assert property (p_por) else $error("power-on reset not held");
   property p_drop;
      $fell(ring_reset) |-> s_rise_edge;
   endproperty
   a_drop: assert property (p_drop) else $error("ring reset dropped off a rise");
   property p_btn;
      (!reset_button_n) [*8] |-> system_reset;
   endproperty
   a_btn: assert property (p_btn) else $error("button reset not held");
   property p_pulse;
      power_on_ok && $rose(ring_reset) |-> s_rise_edge ##0 s_two_wide;
   endproperty
   a_pulse: assert property (p_pulse) else $error("manual ring pulse width wrong");
   property p_defer;
      (!monitor_line_drive_n && power_on_ok) [*8] |-> !$rose(ring_reset);
   endproperty
   a_defer: assert property (p_defer) else $error("ring pulse during line drive");
   property p_line;
      line_count == (!step ? line_q : line_q == `RTG_LINE_LAST ? 6'h00 : line_q + 6'h01)
         && half_line_tick == (line_count == `RTG_LINE_HALF);
   endproperty
   a_line: assert property (p_line) else $error("line counter step wrong");
   property p_field;
      field_count == (lead ? (field_q == LAST ? 10'h000 : field_q)
         : (!trail || hold_q) ? field_q : field_q + 10'h001);
   endproperty
   a_field: assert property (p_field) else $error("field counter step wrong");
   property p_fdec;
      {vdrive_end_pulse, tone_out, field_end_decode_n}
         == {field_count[0] & field_count[4], field_count[4], field_count != LAST};
   endproperty
   a_fdec: assert property (p_fdec) else $error("field decode wrong");
   property p_gate;
      field_b_gate == !field_a_gate && (field_a_gate != ga_q) == (field_count == LAST && field_q != LAST);
   endproperty
   a_gate: assert property (p_gate) else $error("field gate toggle wrong");
endmodule // rtg_sva

bind rtg_timing rtg_sva #(.FIFTY_HZ(FIFTY_HZ)) u_sva (.clk(clk), .nrst(nrst), .power_on_ok(power_on_ok),
   .reset_button_n(reset_button_n), .monitor_line_drive_n(monitor_line_drive_n),
   .pixel_shift_clk(pixel_shift_clk), .system_reset(system_reset), .system_reset_n(system_reset_n),
   .ring_reset(ring_reset), .phase_strobe(phase_strobe), .half_line_tick(half_line_tick),
   .field_end_decode_n(field_end_decode_n), .vdrive_end_pulse(vdrive_end_pulse), .tone_out(tone_out),
   .field_a_gate(field_a_gate), .field_b_gate(field_b_gate), .line_count(line_count), .field_count(field_count));
`default_nettype wire

/* File: sim/rtg_monitor_model.sv */
// Monitor line drive model for the raster timing generator
`timescale 1ns/10ps
`default_nettype none
module rtg_monitor_model (
   input wire clk,
   input wire nrst,
   input wire hold_low,
   input wire line_count_fortytwo_pulse,
   input wire line_count_twentyseven_pulse,
   output wire monitor_line_drive_n
);
   logic active, t27_q;
   // Drive low from count 42 to the end of count 27
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         active <= 1'b0;
         t27_q <= 1'b0;
      end else begin
         t27_q <= line_count_twentyseven_pulse;
         if (line_count_fortytwo_pulse) begin
            active <= 1'b1;
         end else if (t27_q && !line_count_twentyseven_pulse) begin
            active <= 1'b0;
         end
      end
   end
   // Held low on command as a long drive pulse
   assign monitor_line_drive_n = !(active || hold_low);
endmodule // rtg_monitor_model
`default_nettype wire

/* File: sim/tb_top.sv */
// Self-checking testbench for the raster timing generator
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic power_on_ok = 1'b0;
   logic reset_button_n = 1'b1;
   logic hold_low = 1'b0;
   wire mon_n, shclk, sr, sr_n, rr, p0, p3, p6, on_p, five_p, off_p, t27_p, t42_p, half_p;
   wire fa_n, fb_n, fe_n, vde, tone, ga, gb;
   wire [6:0] ps, ps_n;
   wire [5:0] lc;
   wire [9:0] fc;
   int err_total = 0;
   int n_checks = 0;
   int i;
   // Design and far-side model
   rtg_timing #(.FIFTY_HZ(0)) dut (.clk(clk), .nrst(nrst), .power_on_ok(power_on_ok),
      .reset_button_n(reset_button_n), .monitor_line_drive_n(mon_n), .pixel_shift_clk(shclk),
      .system_reset(sr), .system_reset_n(sr_n), .ring_reset(rr), .phase_strobe(ps), .phase_strobe_n(ps_n),
      .phase_zero_strobe(p0), .phase_three_strobe(p3), .phase_six_strobe(p6), .line_drive_on_pulse(on_p),
      .line_count_five_pulse(five_p), .line_drive_off_pulse(off_p), .line_count_twentyseven_pulse(t27_p),
      .line_count_fortytwo_pulse(t42_p), .half_line_tick(half_p), .field_decode_a_n(fa_n),
      .field_decode_b_n(fb_n), .field_end_decode_n(fe_n), .vdrive_end_pulse(vde), .tone_out(tone),
      .field_a_gate(ga), .field_b_gate(gb), .line_count(lc), .field_count(fc));
   rtg_monitor_model u_mon (.clk(clk), .nrst(nrst), .hold_low(hold_low),
      .line_count_fortytwo_pulse(t42_p), .line_count_twentyseven_pulse(t27_p), .monitor_line_drive_n(mon_n));
   // Verdict and end of run
   task automatic conclude();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic bound(input int k, input int lim);
      if (k >= lim) begin
         err_total++;
         conclude();
      end
   endtask
   // Power-on hold and release
   task automatic t_power();
      step(10);
      chk({sr, sr_n, rr, ps}, {3'b101, 7'h01});
      power_on_ok = 1'b1;
      for (i = 0; i < 20 && rr; i++) step(1);
      bound(i, 20);
      chk({sr, sr_n, shclk}, 3'b011);
   endtask
   // Ring circulation after release
   task automatic t_ring();
      logic [6:0] e;
      e = 7'h01;
      repeat (15) begin
         chk({ps_n, ps, p0, p3, p6}, {~e, e, e[0], e[3], e[6]});
         e = {e[5:0], e[6]};
         step(2);
      end
   endtask
   // Line counter walk through a full wrap
   task automatic t_line();
      logic [5:0] k;
      k = lc;
      for (i = 0; i < 20 && lc == k; i++) step(1);
      bound(i, 20);
      k = lc;
      repeat (47) begin
         chk({on_p, five_p, off_p, t27_p, t42_p, half_p}, {k == 6'h01, k == 6'h05, k == 6'h0b,
            k == 6'h1b, k == 6'h2a, k == 6'h2c});
         step(14);
         k = (k == 6'h2c) ? 6'h00 : k + 6'h01;
         chk(lc, k);
      end
   endtask
   // Button press deferred by line drive
   task automatic t_button();
      hold_low = 1'b1;
      step(8);
      reset_button_n = 1'b0;
      step(10);
      chk({sr, sr_n}, 2'b10);
      repeat (30) begin
         chk(rr, 1'b0);
         step(1);
      end
      hold_low = 1'b0;
      for (i = 0; i < 700 && !rr; i++) step(1);
      bound(i, 700);
      chk(shclk, 1'b1);
      step(2);
      chk({rr, ps}, {1'b0, 7'h01});
      step(40);
      chk({rr, sr}, 2'b01);
      reset_button_n = 1'b1;
      step(10);
      chk({sr, sr_n}, 2'b01);
   endtask
   // Field decodes, tone and half-line spacing
   task automatic t_field();
      logic [9:0] c [4] = '{10'h010, 10'h011, 10'h073, 10'h074};
      foreach (c[j]) begin
         for (i = 0; i < 80000 && fc !== c[j]; i++) step(1);
         bound(i, 80000);
         if (j == 3) chk(i, 630);
         chk({vde, tone, fa_n, fb_n, fe_n, ga, gb}, {c[j][0] & c[j][4], c[j][4], c[j] != 10'h073,
            c[j] != 10'h074, 3'b101});
      end
   endtask
   // Master clock
   initial begin
      forever #5 clk = ~clk;
   end
   // Main sequence
   initial begin
      step(16);
      nrst = 1'b1;
      t_power();
      t_ring();
      t_line();
      t_button();
      t_field();
      conclude();
   end
endmodule // tb_top
`default_nettype wire
